/* dv/dac_output_control_registers_bench.sv */
// Self-checking bench for the converter control block.
// Assumes dacoc_top, its checker and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module dac_output_control_registers_bench;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b1;
  logic loadOutput_n = 1'b1;
  logic clearOutput_n = 1'b1;
  logic frameSelect_n, serialClock, serialDataIn, sawEn;
  logic serialDataOut, serialDataOutEn, dacUpdate, feedbackResistorSelect;
  logic outputGroundClamp, outputTristate, outputDrive, codingSelect;
  logic [17:0] dacCode;
  logic [23:0] rdw;
  int fail_count = 0;
  int checks = 0;
  always #5 clk_sys = ~clk_sys;
  dacoc_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .frameSelect_n(frameSelect_n),
    .serialClock(serialClock), .serialDataIn(serialDataIn), .loadOutput_n(loadOutput_n),
    .clearOutput_n(clearOutput_n), .serialDataOut(serialDataOut),
    .serialDataOutEn(serialDataOutEn), .dacCode(dacCode), .dacUpdate(dacUpdate),
    .feedbackResistorSelect(feedbackResistorSelect), .outputGroundClamp(outputGroundClamp),
    .outputTristate(outputTristate), .outputDrive(outputDrive), .codingSelect(codingSelect));
  dacoc_host_model u_host (.clk_sys(clk_sys), .serialDataOut(serialDataOut),
    .serialDataOutEn(serialDataOutEn), .frameSelect_n(frameSelect_n),
    .serialClock(serialClock), .serialDataIn(serialDataIn), .sawEn(sawEn));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [19:0] d);
    u_host.xfer({1'b0, a, d}, 24, 2, rdw);
  endtask
  task automatic rd(input logic [2:0] a, input logic [19:0] exp);
    u_host.xfer({1'b1, a, 20'h00000}, 24, 2, rdw);
    // Slow clock on the shift-out frame
    u_host.xfer(24'h000000, 24, 3, rdw);
    chk(rdw, {1'b1, a, exp});
  endtask
  function automatic logic [23:0] st();
    return {19'h0, feedbackResistorSelect, outputGroundClamp, outputTristate, outputDrive,
      codingSelect};
  endfunction
  function automatic logic [23:0] ex(input logic [19:0] c);
    return {19'h0, c[1], c[2], c[3] | c[2], !(c[3] | c[2]), c[4]};
  endfunction
  task automatic t_power();
    chk(st(), 24'h1c);
    chk(dacCode, 18'h20000);
    rd(3'h2, 20'h0000e);
    rd(3'h3, 20'h00000);
    $display("done power");
  endtask
  task automatic t_config();
    logic [19:0] tbl [5] = '{20'h00000, 20'h00008, 20'h00004, 20'h00002, 20'h00010};
    foreach (tbl[i]) begin
      wr(3'h2, tbl[i]);
      chk(st(), ex(tbl[i]));
    end
    rd(3'h2, 20'h00010);
    wr(3'h2, 20'h00020);
    u_host.xfer({1'b1, 3'h2, 20'h00000}, 24, 2, rdw);
    u_host.xfer(24'h000000, 24, 2, rdw);
    chk(rdw, 24'hffffff);
    chk(sawEn, 1'b0);
    wr(3'h2, 20'h00000);
    rd(3'h2, 20'h00000);
    chk(sawEn, 1'b1);
    u_host.xfer({1'b0, 3'h2, 20'h0000e}, 23, 2, rdw);
    u_host.xfer({1'b0, 3'h2, 20'h0000e}, 25, 2, rdw);
    chk(st(), ex(20'h00000));
    $display("done config");
  endtask
  task automatic t_load_clear();
    wr(3'h3, {18'h0abcd, 2'b11});
    rd(3'h3, {18'h0abcd, 2'b00});
    wr(3'h1, {18'h01234, 2'b00});
    loadOutput_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    loadOutput_n = 1'b1;
    chk(dacCode, 18'h21234);
    clearOutput_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(dacCode, 18'h2abcd);
    wr(3'h1, {18'h00555, 2'b00});
    wr(3'h4, 20'h00001);
    clearOutput_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(dacCode, 18'h2abcd);
    wr(3'h4, 20'h00001);
    chk(dacCode, 18'h20555);
    loadOutput_n = 1'b0;
    wr(3'h4, 20'h00002);
    loadOutput_n = 1'b1;
    chk(dacCode, 18'h20555);
    for (int i = 0; i < 2; i++) begin
      wr(3'h4, 20'h00002);
      chk(dacCode, 18'h2abcd);
      wr(3'h4, 20'h00001);
      chk(dacCode, 18'h20555);
    end
    wr(3'h2, 20'h00010);
    wr(3'h4, 20'h00001);
    chk(dacCode, 18'h00555);
    rd(3'h1, {18'h00555, 2'b00});
    $display("done load clear");
  endtask
  task automatic t_soft_reset();
    wr(3'h4, 20'h00004);
    chk(st(), 24'h1c);
    chk(dacCode, 18'h20000);
    rd(3'h3, 20'h00000);
    $display("done soft reset");
  endtask
  task automatic final_report();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    // Real edge on reset so state is defined before the first clock
    #1;
    rst_b = 1'b0;
    repeat (10) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (2) @(negedge clk_sys);
    t_power();
    t_config();
    t_load_clear();
    t_soft_reset();
    final_report();
  end
  // About 4400 cycles expected; allow far more
  initial begin
    #500us;
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire

/* dv/dacoc_host_model.sv */
// Host side of the 3-wire serial link; frames words MSB first.
// Assumes the bench calls xfer; pins move on clk_sys falling edges.
`timescale 1ns/100ps
`default_nettype none
module dacoc_host_model (
  input wire logic clk_sys,
  input wire logic serialDataOut,
  input wire logic serialDataOutEn,
  output logic frameSelect_n,
  output logic serialClock,
  output logic serialDataIn,
  output logic sawEn
);
  initial begin
    frameSelect_n = 1'b1;
    serialClock = 1'b1;
    serialDataIn = 1'b0;
    sawEn = 1'b0;
  end
  // Edge count is free so broken frames can be sent
  task automatic xfer(input logic [23:0] w, input int n, input int ph, output logic [23:0] rd);
    rd = 24'h000000;
    sawEn = 1'b0;
    @(negedge clk_sys);
    frameSelect_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    for (int i = 0; i < n; i++) begin
      serialDataIn = w[23 - (i % 24)];
      repeat (ph) @(negedge clk_sys);
      // Undriven line read as the inverse so stale data cannot pass
      rd = {rd[22:0], serialDataOutEn ? serialDataOut : ~serialDataOut};
      sawEn = sawEn | serialDataOutEn;
      serialClock = 1'b0;
      repeat (ph) @(negedge clk_sys);
      serialClock = 1'b1;
    end
    repeat (ph) @(negedge clk_sys);
    frameSelect_n = 1'b1;
    // Released line must not keep a stale level
    serialDataIn = ~serialDataIn;
    repeat (4) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

/* dv/dacoc_top_props.sv */
// Port checker for the converter control block.
// Assumes every port is sampled on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module dacoc_top_props (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic frameSelect_n,
  input wire logic loadOutput_n,
  input wire logic clearOutput_n,
  input wire logic serialDataOut,
  input wire logic serialDataOutEn,
  input wire logic [17:0] dacCode,
  input wire logic dacUpdate,
  input wire logic feedbackResistorSelect,
  input wire logic outputGroundClamp,
  input wire logic outputTristate,
  input wire logic outputDrive,
  input wire logic codingSelect
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  a_clamp_forces_tri: assert property (outputGroundClamp |-> outputTristate)
    else $error("clamp without tristate");
  a_drive_decode: assert property (outputDrive == !(outputTristate || outputGroundClamp))
    else $error("output state decode wrong");
  a_update_one_cycle: assert property (dacUpdate |=> !dacUpdate)
    else $error("update pulse too long");
  a_sdo_quiet_off: assert property (!serialDataOutEn |-> !serialDataOut)
    else $error("readback bit while disabled");
  a_sdo_off_end: assert property ($rose(frameSelect_n) |-> ##2 !serialDataOutEn)
    else $error("readback still driving after frame");
  a_ctrl_frame_end: assert property ($changed({feedbackResistorSelect, outputGroundClamp,
    codingSelect}) |-> $past(frameSelect_n))
    else $error("control changed inside a frame");
  a_reset_defaults: assert property (disable iff (1'b0) !rst_b |-> outputGroundClamp &&
    outputTristate && feedbackResistorSelect && !codingSelect && !serialDataOutEn &&
    dacCode == 18'h20000)
    else $error("reset state wrong");
  a_load_pin_update: assert property ($fell(loadOutput_n) && clearOutput_n && frameSelect_n
    |-> ##[1:2] dacUpdate)
    else $error("load pin gave no update");
  a_clear_pin_blocks: assert property (!clearOutput_n [*4] |-> !dacUpdate)
    else $error("update while clear held");
endmodule
bind dacoc_top dacoc_top_props u_props (.*);
`default_nettype wire

/* hw/dacoc_frame_rx.sv */
// Serial frame receiver: finds frame and clock edges, counts falling clock
// edges and delivers a 24-bit word only for a frame of exactly 24 edges.
// Assumes frame, clock and data pins already synchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none
`include "dacoc_map.svh"

module dacoc_frame_rx (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic frameSelect_n,
  input wire logic serialClock,
  input wire logic serialDataIn,
  output logic frameStart,
  output logic sclkFall,
  output logic frameEnd,
  output logic frameValid,
  output logic [`DACOC_FRAME_BITS-1:0] frameWord
);

  localparam logic [`DACOC_CNT_W-1:0] FULL = `DACOC_CNT_W'(`DACOC_FRAME_BITS);
  localparam logic [`DACOC_CNT_W-1:0] OVER = `DACOC_CNT_W'(`DACOC_FRAME_BITS + 1);

  dacoc_pkg::dacoc_rx_t rx_reg;
  dacoc_pkg::dacoc_rx_t rx_next;

  always_comb begin
    rx_next = rx_reg;
    rx_next.sclkPrev = serialClock;
    rx_next.framePrev = frameSelect_n;
    rx_next.frameStart = 1'b0;
    rx_next.sclkFall = 1'b0;
    rx_next.frameEnd = 1'b0;
    rx_next.frameValid = 1'b0;
    if (rx_reg.framePrev && !frameSelect_n) begin
      rx_next.frameStart = 1'b1;
      rx_next.edgeCount = '0;
    end
    // Data sampled on falling clock edge, MSB first
    if (!frameSelect_n && !rx_reg.framePrev && rx_reg.sclkPrev && !serialClock) begin
      rx_next.sclkFall = 1'b1;
      rx_next.shift = {rx_reg.shift[`DACOC_FRAME_BITS-2:0], serialDataIn};
      // Saturate so any overlong frame stays invalid
      if (rx_reg.edgeCount != OVER) begin
        rx_next.edgeCount = rx_reg.edgeCount + 1'b1;
      end
    end
    if (!rx_reg.framePrev && frameSelect_n) begin
      rx_next.frameEnd = 1'b1;
      if (rx_reg.edgeCount == FULL) begin
        rx_next.frameValid = 1'b1;
        rx_next.word = rx_reg.shift;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_reg <= '{sclkPrev: 1'b0, framePrev: 1'b1, default: '0};
    end else begin
      rx_reg <= rx_next;
    end
  end

  assign frameStart = rx_reg.frameStart;
  assign sclkFall = rx_reg.sclkFall;
  assign frameEnd = rx_reg.frameEnd;
  assign frameValid = rx_reg.frameValid;
  assign frameWord = rx_reg.word;

endmodule
`default_nettype wire

/* hw/dacoc_top.sv */
// Control registers of an 18-bit voltage-output converter behind a 3-wire
// serial port, with load and clear pins and output state decoding.
// Assumes all pins synchronous to clk_sys; rst_b is the power-on reset.
`timescale 1ns/100ps
`default_nettype none
`include "dacoc_map.svh"

module dacoc_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic frameSelect_n,
  input wire logic serialClock,
  input wire logic serialDataIn,
  input wire logic loadOutput_n,
  input wire logic clearOutput_n,
  output logic serialDataOut,
  output logic serialDataOutEn,
  output logic [17:0] dacCode,
  output logic dacUpdate,
  output logic feedbackResistorSelect,
  output logic outputGroundClamp,
  output logic outputTristate,
  output logic outputDrive,
  output logic codingSelect
);

  localparam dacoc_pkg::dacoc_state_t DEFAULTS = '{
    cfg: `DACOC_CONFIG_RESET,
    clearCode: `DACOC_CLEAR_RESET,
    inputCode: `DACOC_DATA_RESET,
    dacCode: `DACOC_DATA_RESET,
    loadPrev: 1'b1,
    rbState: dacoc_pkg::RB_IDLE,
    rbAddr: `DACOC_ADDR_NOP,
    rbShift: '0,
    serial_data_out: 1'b0,
    sdoEn: 1'b0,
    outCode: `DACOC_DATA_RESET ^ `DACOC_CODE_MSB,
    feedback: 1'b1,
    clamp: 1'b1,
    tristate: 1'b1,
    drive: 1'b0,
    coding: 1'b0,
    update: 1'b0
  };

  logic rxStart;
  logic rxFall;
  logic rxEnd;
  logic rxValid;
  logic [`DACOC_FRAME_BITS-1:0] rxWord;

  dacoc_pkg::dacoc_state_t st_reg;
  dacoc_pkg::dacoc_state_t st_next;

  dacoc_frame_rx u_rx (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .frameSelect_n(frameSelect_n),
    .serialClock(serialClock),
    .serialDataIn(serialDataIn),
    .frameStart(rxStart),
    .sclkFall(rxFall),
    .frameEnd(rxEnd),
    .frameValid(rxValid),
    .frameWord(rxWord)
  );

  // Readback word: echo of the request header, then the register contents
  function automatic logic [`DACOC_FRAME_BITS-1:0] readWord(
    input dacoc_pkg::dacoc_state_t s
  );
    logic [19:0] data;
    data = '0;
    case (s.rbAddr)
      `DACOC_ADDR_DATA: data = {s.dacCode, 2'h0};
      `DACOC_ADDR_CONFIG: data = s.cfg;
      `DACOC_ADDR_CLEAR: data = {s.clearCode, 2'h0};
      default: data = '0;
    endcase
    readWord = {1'b1, s.rbAddr, data};
  endfunction

  logic rw;
  logic [2:0] addr;
  logic [19:0] data;
  logic softReset;

  always_comb begin
    st_next = st_reg;
    st_next.update = 1'b0;
    st_next.loadPrev = loadOutput_n;
    softReset = 1'b0;
    rw = rxWord[`DACOC_RW_BIT];
    addr = rxWord[`DACOC_ADDR_HI:`DACOC_ADDR_LO];
    data = rxWord[`DACOC_DATA_HI:0];

    // Readback shifting during the frame after a read request
    if (rxStart) begin
      if (st_reg.rbState == dacoc_pkg::RB_ARMED) begin
        st_next.rbShift = readWord(st_reg);
        st_next.sdoEn = !st_reg.cfg[`DACOC_CFG_SDO_DIS];
        // Disabled pin still walks the word but never shows a bit
        st_next.serial_data_out = st_next.rbShift[`DACOC_FRAME_BITS-1] && st_next.sdoEn;
        st_next.rbState = dacoc_pkg::RB_SHIFT;
      end
    end
    if (rxFall && st_reg.rbState == dacoc_pkg::RB_SHIFT) begin
      st_next.rbShift = {st_reg.rbShift[`DACOC_FRAME_BITS-2:0], 1'b0};
      st_next.serial_data_out = st_reg.rbShift[`DACOC_FRAME_BITS-2] && st_reg.sdoEn;
    end
    if (rxEnd) begin
      st_next.sdoEn = 1'b0;
      st_next.serial_data_out = 1'b0;
      st_next.rbState = dacoc_pkg::RB_IDLE;
    end

    // Asynchronous update on a falling load pin edge, blocked by clear
    if (st_reg.loadPrev && !loadOutput_n && clearOutput_n) begin
      st_next.dacCode = st_reg.inputCode;
      st_next.update = 1'b1;
    end

    if (rxValid) begin
      if (rw) begin
        case (addr)
          `DACOC_ADDR_DATA,
          `DACOC_ADDR_CONFIG,
          `DACOC_ADDR_CLEAR: begin
            st_next.rbState = dacoc_pkg::RB_ARMED;
            st_next.rbAddr = addr;
          end
          default: ;
        endcase
      end else begin
        case (addr)
          `DACOC_ADDR_DATA: begin
            st_next.inputCode = data[`DACOC_DATA_HI:`DACOC_CODE_LO];
            // Load pin held low gives an update at frame end
            if (!loadOutput_n && clearOutput_n) begin
              st_next.dacCode = data[`DACOC_DATA_HI:`DACOC_CODE_LO];
              st_next.update = 1'b1;
            end
          end
          `DACOC_ADDR_CONFIG: begin
            // Reserved bits dropped so they read back as zero
            st_next.cfg = '0;
            st_next.cfg[`DACOC_CFG_FEEDBACK] = data[`DACOC_CFG_FEEDBACK];
            st_next.cfg[`DACOC_CFG_CLAMP] = data[`DACOC_CFG_CLAMP];
            st_next.cfg[`DACOC_CFG_TRISTATE] = data[`DACOC_CFG_TRISTATE];
            st_next.cfg[`DACOC_CFG_CODING] = data[`DACOC_CFG_CODING];
            st_next.cfg[`DACOC_CFG_SDO_DIS] = data[`DACOC_CFG_SDO_DIS];
          end
          `DACOC_ADDR_CLEAR: begin
            st_next.clearCode = data[`DACOC_DATA_HI:`DACOC_CODE_LO];
          end
          `DACOC_ADDR_COMMAND: begin
            // Decoded straight from the frame, nothing kept
            if (data[`DACOC_CMD_LOAD] && clearOutput_n) begin
              st_next.dacCode = st_reg.inputCode;
              st_next.update = 1'b1;
            end
            if (data[`DACOC_CMD_CLEAR] && loadOutput_n) begin
              st_next.dacCode = st_reg.clearCode;
              st_next.update = 1'b1;
            end
            softReset = data[`DACOC_CMD_RESET];
          end
          default: ;
        endcase
      end
    end

    // Clear pin overrides any load while low
    if (!clearOutput_n) begin
      st_next.dacCode = st_reg.clearCode;
      st_next.update = (st_reg.dacCode != st_reg.clearCode);
    end

    if (softReset) begin
      st_next = DEFAULTS;
      st_next.update = 1'b1;
    end

    // Registered output decode
    st_next.coding = st_next.cfg[`DACOC_CFG_CODING];
    // Ladder expects offset binary; flip MSB for twos complement
    st_next.outCode = st_next.coding ? st_next.dacCode
                                     : (st_next.dacCode ^ `DACOC_CODE_MSB);
    st_next.feedback = st_next.cfg[`DACOC_CFG_FEEDBACK];
    st_next.clamp = st_next.cfg[`DACOC_CFG_CLAMP];
    // Clamp forces tristate whatever the tristate bit says
    st_next.tristate = st_next.cfg[`DACOC_CFG_TRISTATE] || st_next.cfg[`DACOC_CFG_CLAMP];
    st_next.drive = !st_next.tristate;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= DEFAULTS;
    end else begin
      st_reg <= st_next;
    end
  end

  assign serialDataOut = st_reg.serial_data_out;
  assign serialDataOutEn = st_reg.sdoEn;
  assign dacCode = st_reg.outCode;
  assign dacUpdate = st_reg.update;
  assign feedbackResistorSelect = st_reg.feedback;
  assign outputGroundClamp = st_reg.clamp;
  assign outputTristate = st_reg.tristate;
  assign outputDrive = st_reg.drive;
  assign codingSelect = st_reg.coding;

endmodule
`default_nettype wire

/* include/dacoc_map.svh */
// Offsets, field positions, reset values and frame figures of the converter
// control block. Definitions only; included by the package and design files.
`ifndef DACOC_MAP_SVH
`define DACOC_MAP_SVH

// Frame layout
`define DACOC_FRAME_BITS 24
`define DACOC_CNT_W 5
`define DACOC_RW_BIT 23
`define DACOC_ADDR_HI 22
`define DACOC_ADDR_LO 20
`define DACOC_DATA_HI 19
`define DACOC_CODE_LO 2

// Register addresses
`define DACOC_ADDR_NOP 3'h0
`define DACOC_ADDR_DATA 3'h1
`define DACOC_ADDR_CONFIG 3'h2
`define DACOC_ADDR_CLEAR 3'h3
`define DACOC_ADDR_COMMAND 3'h4

// Configuration field positions
`define DACOC_CFG_FEEDBACK 1
`define DACOC_CFG_CLAMP 2
`define DACOC_CFG_TRISTATE 3
`define DACOC_CFG_CODING 4
`define DACOC_CFG_SDO_DIS 5

// Command field positions
`define DACOC_CMD_LOAD 0
`define DACOC_CMD_CLEAR 1
`define DACOC_CMD_RESET 2

// Reset values and the code MSB mask
`define DACOC_CONFIG_RESET 20'h0000e
`define DACOC_CLEAR_RESET 18'h00000
`define DACOC_DATA_RESET 18'h00000
`define DACOC_CODE_MSB 18'h20000

`endif

/* include/dacoc_pkg.sv */
// Types of the converter control block: readback states and state records.
// Assumes dacoc_map.svh on the include path.
`default_nettype none
`include "dacoc_map.svh"

package dacoc_pkg;

  typedef enum logic [2:0] {
    RB_IDLE = 3'b001,
    RB_ARMED = 3'b010,
    RB_SHIFT = 3'b100
  } dacoc_rb_t;

  typedef struct packed {
    logic sclkPrev;
    logic framePrev;
    logic [`DACOC_CNT_W-1:0] edgeCount;
    logic [`DACOC_FRAME_BITS-1:0] shift;
    logic [`DACOC_FRAME_BITS-1:0] word;
    logic frameStart;
    logic sclkFall;
    logic frameEnd;
    logic frameValid;
  } dacoc_rx_t;

  typedef struct packed {
    logic [19:0] cfg;
    logic [17:0] clearCode;
    logic [17:0] inputCode;
    logic [17:0] dacCode;
    logic loadPrev;
    dacoc_rb_t rbState;
    logic [2:0] rbAddr;
    logic [`DACOC_FRAME_BITS-1:0] rbShift;
    logic serial_data_out;
    logic sdoEn;
    logic [17:0] outCode;
    logic feedback;
    logic clamp;
    logic tristate;
    logic drive;
    logic coding;
    logic update;
  } dacoc_state_t;

endpackage
`default_nettype wire
